// [testbench/tmr_host_model.sv]
// Purpose: host processor model that drives the byte-wide register bus
// Assumes: strobes last one sys_clk cycle and change just after a rising edge
// Notes: a released address or data bus shows the inverse of its last value
`timescale 1ns/100ps
module tmr_host_model (
  input wire logic sys_clk,
  output logic [4:0] busAddr,
  output logic busCs,
  output logic busRd,
  output logic busWr,
  output logic [7:0] busWrData
);
  logic [7:0] expQ[$];
  string nameQ[$];

  initial begin
    busAddr = 5'h00;
    busCs = 1'b0;
    busRd = 1'b0;
    busWr = 1'b0;
    busWrData = 8'h00;
  end

  task automatic writeReg(input logic [4:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    busAddr <= addr;
    busWrData <= data;
    busCs <= 1'b1;
    busWr <= 1'b1;
    @(posedge sys_clk);
    busCs <= 1'b0;
    busWr <= 1'b0;
    busAddr <= ~addr;
    busWrData <= ~data;
  endtask

  // the expected byte is noted before the strobe so the watcher finds it
  task automatic readReg(input logic [4:0] addr, input logic [7:0] exp, input string what);
    expQ.push_back(exp);
    nameQ.push_back(what);
    @(posedge sys_clk);
    busAddr <= addr;
    busCs <= 1'b1;
    busRd <= 1'b1;
    @(posedge sys_clk);
    busCs <= 1'b0;
    busRd <= 1'b0;
    busAddr <= ~addr;
  endtask

  task automatic enterOneShot(input logic [4:0] lo, input logic [4:0] ctrl, input logic [7:0] n);
    writeReg(lo, 8'h00);
    writeReg(lo + 5'h01, 8'h00);
    writeReg(ctrl, 8'h01);
    writeReg(ctrl, 8'h06);
    writeReg(lo, n);
    writeReg(ctrl, 8'h07);
  endtask

  // latch while idle: callers only do this with the timer clock pin quiet
  task automatic latchCount(input logic [4:0] ctrl);
    writeReg(ctrl, 8'h47);
  endtask
endmodule

// [testbench/tmr_oneshot_readback_bench.sv]
// Purpose: self-checking bench for the two-timer register block
// Assumes: 25 MHz sys_clk, timer clock pin toggled slowly by the bench
// Notes: reads are scored from a queue; pin outputs are checked directly
`timescale 1ns/100ps
module tmr_oneshot_readback_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic gateInputZero = 1'b0;
  logic gateInputOne = 1'b0;
  logic timerClockIn = 1'b0;
  logic [4:0] busAddr;
  logic busCs, busRd, busWr, rdTaken = 1'b0;
  logic [7:0] busWrData, busRdData, d, n;
  logic multiFunctionOutput, timerOneOutput, interruptOutput;
  int badCount = 0;
  int compares = 0;
  int irqCount = 0;
  int base, seed = 63;

  always #20 sys_clk = ~sys_clk;

  tmr_oneshot_readback u_dut (.sys_clk(sys_clk), .rst(rst), .busAddr(busAddr),
    .busCs(busCs), .busRd(busRd), .busWr(busWr), .busWrData(busWrData),
    .busRdData(busRdData), .gateInputZero(gateInputZero), .gateInputOne(gateInputOne),
    .timerClockIn(timerClockIn), .multiFunctionOutput(multiFunctionOutput),
    .timerOneOutput(timerOneOutput), .interruptOutput(interruptOutput));

  tmr_host_model u_host (.sys_clk(sys_clk), .busAddr(busAddr), .busCs(busCs),
    .busRd(busRd), .busWr(busWr), .busWrData(busWrData));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic giveVerdict();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one input clock period: seven sys_clk cycles, well above the two-cycle minimum
  task automatic tick();
    @(posedge sys_clk);
    timerClockIn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    timerClockIn <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic outIs(input logic v, input string what);
    @(negedge sys_clk);
    check(what, {15'h0000, multiFunctionOutput}, {15'h0000, v});
  endtask

  // reload tick, then n decrements; the output must drop on the last one
  task automatic runPulse();
    for (int i = 1; i <= n + 1; i++) begin
      tick();
      outIs(i <= n, "pulse out");
    end
    base++;
    check("irq count", 16'(irqCount), 16'(base));
  endtask

  always @(posedge sys_clk) rdTaken <= busCs & busRd;
  always @(posedge sys_clk) if (interruptOutput === 1'b1) irqCount <= irqCount + 1;

  // watcher: data is settled by the falling edge after the taken strobe
  always @(negedge sys_clk) begin
    if (rdTaken === 1'b1 && u_host.expQ.size() > 0) begin
      check(u_host.nameQ.pop_front(), {8'h00, busRdData}, {8'h00, u_host.expQ.pop_front()});
    end
  end

  initial begin
    #(40 * 20000);
    badCount++;
    giveVerdict();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    u_host.readReg(tmr_pkg::ADDR_STATUS, 8'h00, "status reset");
    u_host.readReg(tmr_pkg::ADDR_CTRL0, 8'h00, "ctrl0 reset");
    u_host.readReg(tmr_pkg::ADDR_T1_HI, 8'h00, "t1 hi reset");
    $display("test reset done");
    d = 8'($random(seed));
    u_host.writeReg(5'h05, d);
    u_host.writeReg(tmr_pkg::ADDR_STATUS, 8'h40);
    u_host.writeReg(tmr_pkg::ADDR_CTRL0, ~d);
    u_host.readReg(tmr_pkg::ADDR_CTRL0, ~d, "bank1 reg");
    u_host.writeReg(tmr_pkg::ADDR_STATUS, 8'hff);
    u_host.readReg(tmr_pkg::ADDR_STATUS, 8'hc0, "status page1");
    u_host.writeReg(5'h05, d ^ 8'h5a);
    u_host.readReg(5'h05, d ^ 8'h5a, "page1 ram");
    u_host.writeReg(tmr_pkg::ADDR_STATUS, 8'h00);
    u_host.readReg(5'h05, d, "page0 byte");
    u_host.readReg(tmr_pkg::ADDR_CTRL0, 8'h00, "ctrl0 bank0");
    $display("test paging done");
    for (int m = 0; m < 4; m++) begin
      u_host.writeReg(tmr_pkg::ADDR_CTRL1, {2'b00, 3'b101, 2'(m), 1'b0});
      u_host.readReg(tmr_pkg::ADDR_CTRL1, {2'b00, 3'b101, 2'(m), 1'b0}, "mode code");
    end
    u_host.writeReg(tmr_pkg::ADDR_CTRL1, 8'h00);
    u_host.writeReg(tmr_pkg::ADDR_T1_LO, ~d);
    u_host.writeReg(tmr_pkg::ADDR_T1_HI, d);
    u_host.readReg(tmr_pkg::ADDR_T1_HI, d, "t1 preset hi");
    u_host.readReg(tmr_pkg::ADDR_T1_LO, ~d, "t1 preset lo");
    $display("test modes and presets done");
    n = 8'h02 + 8'($random(seed) & 3);
    u_host.enterOneShot(tmr_pkg::ADDR_T0_LO, tmr_pkg::ADDR_CTRL0, n);
    base = irqCount;
    tick();
    outIs(1'b0, "idle out");
    u_host.writeReg(tmr_pkg::ADDR_CTRL0, 8'h87);
    outIs(1'b1, "trigger out");
    check("irq at trigger", 16'(irqCount), 16'(base));
    tick();
    tick();
    u_host.latchCount(tmr_pkg::ADDR_CTRL0);
    u_host.readReg(tmr_pkg::ADDR_T0_HI, 8'h00, "latched hi");
    u_host.readReg(tmr_pkg::ADDR_T0_LO, n - 8'h01, "latched lo");
    u_host.readReg(tmr_pkg::ADDR_T0_LO, n, "preset after latch");
    u_host.readReg(tmr_pkg::ADDR_CTRL0, 8'h07, "read bit cleared");
    u_host.latchCount(tmr_pkg::ADDR_CTRL0);
    u_host.writeReg(tmr_pkg::ADDR_CTRL0, 8'h87);
    u_host.readReg(tmr_pkg::ADDR_T0_LO, n, "preset after abort");
    tick();
    // retrigger with the hold bit already one
    u_host.writeReg(tmr_pkg::ADDR_CTRL0, 8'h87);
    outIs(1'b1, "retrigger out");
    runPulse();
    $display("test software trigger done");
    // either gate pin triggers both waiting timers
    u_host.enterOneShot(tmr_pkg::ADDR_T1_LO, tmr_pkg::ADDR_CTRL1, n);
    gateInputOne <= 1'b1;
    repeat (5) @(posedge sys_clk);
    outIs(1'b1, "gate one out");
    check("t1 gate out", {15'h0000, timerOneOutput}, 16'h0001);
    @(posedge sys_clk);
    gateInputOne <= 1'b0;
    tick();
    tick();
    // timer 1 latch, high byte first
    u_host.latchCount(tmr_pkg::ADDR_CTRL1);
    u_host.readReg(tmr_pkg::ADDR_T1_HI, 8'h00, "t1 latched hi");
    u_host.readReg(tmr_pkg::ADDR_T1_LO, n - 8'h01, "t1 latched lo");
    gateInputZero <= 1'b1;
    repeat (5) @(posedge sys_clk);
    gateInputZero <= 1'b0;
    runPulse();
    check("t1 pulse end", {15'h0000, timerOneOutput}, 16'h0000);
    $display("test gate trigger done");
    u_host.writeReg(tmr_pkg::ADDR_CTRL0, 8'h87);
    tick();
    u_host.writeReg(tmr_pkg::ADDR_CTRL0, 8'h06);
    // the counter sees the cleared run bit one cycle after the write lands
    @(posedge sys_clk);
    outIs(1'b0, "stopped out");
    u_host.writeReg(tmr_pkg::ADDR_CTRL0, 8'h46);
    u_host.readReg(tmr_pkg::ADDR_T0_LO, 8'h00, "stopped count");
    u_host.writeReg(tmr_pkg::ADDR_CTRL0, 8'h07);
    tick();
    outIs(1'b0, "restart idle");
    $display("test stop done");
    repeat (3) @(posedge sys_clk);
    giveVerdict();
  end
endmodule

// [verilog/tmr_counter.sv]
// Purpose: one 16-bit countdown channel with four modes, one-shot retrigger included
// Assumes: tick is a one-cycle enable per input clock period; trigger is a one-cycle pulse
// Notes: a preset of zero in the single-pulse or one-shot modes lasts one input period
`timescale 1ns/100ps
module tmr_counter (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic runBit,
  input wire logic [1:0] modeSel,
  input wire logic suspend,
  input wire logic trigger,
  input wire logic [15:0] presetValue,
  output logic [15:0] countValue,
  output logic timerOut,
  output logic zeroPulse,
  output logic runClearPulse
);
  tmr_pkg::tmr_state_t state_reg, state_next;
  logic [15:0] count_reg, count_next;
  logic out_reg, out_next;
  logic load_reg, load_next;
  logic zero_reg, zero_next;
  logic clr_reg, clr_next;
  logic oneShot;

  assign oneShot = (modeSel == tmr_pkg::MODE_ONESHOT);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    out_next = out_reg;
    load_next = load_reg;
    zero_next = 1'b0;
    clr_next = 1'b0;
    // RULE15 stop resets
    if (!runBit) begin
      state_next = tmr_pkg::ST_STOP;
      count_next = tmr_pkg::COUNT_RESET;
      out_next = 1'b0;
      load_next = 1'b0;
    end else begin
      unique case (state_reg)
        tmr_pkg::ST_STOP: begin
          // RULE1 one-shot waits quietly
          state_next = oneShot ? tmr_pkg::ST_WAIT : tmr_pkg::ST_RUN;
          load_next = !oneShot;
        end
        tmr_pkg::ST_WAIT: begin
          // RULE2 output active at once
          if (oneShot && trigger) begin
            out_next = 1'b1;
            load_next = 1'b1;
            state_next = tmr_pkg::ST_RUN;
          end
        end
        tmr_pkg::ST_RUN: begin
          // RULE3 retrigger reloads, output kept
          if (oneShot && trigger) begin
            load_next = 1'b1;
          end else if (tick && (oneShot || !suspend)) begin
            if (load_reg) begin
              count_next = presetValue;
              load_next = 1'b0;
              out_next = 1'b1;
            end else if (count_reg > tmr_pkg::COUNT_LAST) begin
              count_next = count_reg - tmr_pkg::COUNT_LAST;
            end else begin
              // RULE6 interrupt only at zero
              unique case (modeSel)
                tmr_pkg::MODE_SINGLE: begin
                  out_next = 1'b0;
                  zero_next = 1'b1;
                  clr_next = 1'b1;
                  count_next = tmr_pkg::COUNT_RESET;
                  state_next = tmr_pkg::ST_WAIT;
                end
                tmr_pkg::MODE_RATE: begin
                  out_next = 1'b0;
                  zero_next = 1'b1;
                  count_next = tmr_pkg::COUNT_RESET;
                  load_next = 1'b1;
                end
                tmr_pkg::MODE_SQUARE: begin
                  out_next = !out_reg;
                  zero_next = out_reg;
                  count_next = presetValue;
                end
                tmr_pkg::MODE_ONESHOT: begin
                  // RULE5 pulse spans N input periods
                  out_next = 1'b0;
                  zero_next = 1'b1;
                  count_next = tmr_pkg::COUNT_RESET;
                  state_next = tmr_pkg::ST_WAIT;
                end
              endcase
            end
          end
        end
        default: state_next = tmr_pkg::ST_STOP;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= tmr_pkg::ST_STOP;
      count_reg <= tmr_pkg::COUNT_RESET;
      out_reg <= 1'b0;
      load_reg <= 1'b0;
      zero_reg <= 1'b0;
      clr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      out_reg <= out_next;
      load_reg <= load_next;
      zero_reg <= zero_next;
      clr_reg <= clr_next;
    end
  end

  assign countValue = count_reg;
  assign timerOut = out_reg;
  assign zeroPulse = zero_reg;
  assign runClearPulse = clr_reg;

  AST_WAIT_QUIET: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
    (runBit && oneShot && state_reg == tmr_pkg::ST_WAIT && !trigger) ##1 runBit |-> !timerOut)
    else $error("one-shot output active without a trigger");
  AST_TRIG_OUT: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
    (runBit && oneShot && state_reg == tmr_pkg::ST_WAIT && trigger) |=> timerOut)
    else $error("trigger did not raise output next cycle");
  AST_RETRIG_KEEP: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
    (runBit && oneShot && state_reg == tmr_pkg::ST_RUN && trigger) ##1 runBit
      |-> timerOut == $past(timerOut))
    else $error("retrigger changed output state");
  AST_RETRIG_LOAD: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
    (runBit && oneShot && state_reg == tmr_pkg::ST_RUN && trigger)
      ##1 (runBit && oneShot && tick && !trigger) |=> countValue == $past(presetValue))
    else $error("retrigger did not reload preset");
  AST_ZERO_CAUSE: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    (zeroPulse && $past(oneShot)) |-> ($past(countValue) <= 16'h0001 && !$past(trigger)))
    else $error("one-shot interrupt not caused by zero count");
  AST_STOP_CLEAR: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
    !runBit |=> (countValue == 16'h0000 && !timerOut && state_reg == tmr_pkg::ST_STOP))
    else $error("stop did not clear counter and output");
endmodule

// [verilog/tmr_oneshot_readback.sv]
// Purpose: paged register file with two countdown timers and latched count readback
// Assumes: bus strobes are one-cycle pulses from logic on sys_clk; pins are asynchronous
// Notes: read data is registered and valid on the cycle after the read strobe
`timescale 1ns/100ps
// Overview of operation
// RULE1: one-shot mode, once running, keeps output inactive until a trigger arrives.
// RULE2: a trigger sets output at once; next input clock loads preset and counts.
// RULE3: retrigger reloads preset and restarts countdown, output state unchanged.
// RULE4: trigger accepted any time, from either gate pin or the hold/gate bit.
// RULE5: one-shot output pulse lasts preset count times input clock period.
// RULE6: one-shot interrupt fires only when the count reaches zero.
// RULE7: software enters one-shot via single-pulse mode, zero count, started first.
// RULE8: with read bit clear, timer data addresses return the preset value.
// RULE9: setting read bit copies running count into two holding bytes for reading.
// RULE10: reading a timer low byte clears its read bit automatically.
// RULE11: host should align its read-bit write to the timer decrement clock.
// RULE12: five address bits reach 32 locations, banking extends to 67.
// RULE13: page 0 holds registers, page 1 RAM; status at every setting.
// RULE14: nine control registers share five locations via bank select; timers bank 0.
// RULE15: run bit starts timer; clearing it resets counter for a fresh start.
// RULE16: each write of one to hold/gate bit retriggers in one-shot mode.
// RULE17: writing zero to read bit aborts latched read, presets return.
// RULE18: two mode bits select the mode; both set is the one-shot.
// RULE19: gate pins are synchronised before their rising edges are detected.
module tmr_oneshot_readback (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] busAddr,
  input wire logic busCs,
  input wire logic busRd,
  input wire logic busWr,
  input wire logic [7:0] busWrData,
  output logic [7:0] busRdData,
  input wire logic gateInputZero,
  input wire logic gateInputOne,
  input wire logic timerClockIn,
  output logic multiFunctionOutput,
  output logic timerOneOutput,
  output logic interruptOutput
);
  logic pageSel_reg, pageSel_next;
  logic bankSel_reg, bankSel_next;
  logic [7:0] ctrl_reg [tmr_pkg::TIMER_COUNT];
  logic [7:0] ctrl_next [tmr_pkg::TIMER_COUNT];
  logic [15:0] preset_reg [tmr_pkg::TIMER_COUNT];
  logic [15:0] preset_next [tmr_pkg::TIMER_COUNT];
  logic [15:0] hold_reg [tmr_pkg::TIMER_COUNT];
  logic [15:0] hold_next [tmr_pkg::TIMER_COUNT];
  logic [7:0] bankOne_reg [tmr_pkg::BANK1_REGS];
  logic [7:0] bankOne_next [tmr_pkg::BANK1_REGS];
  logic [7:0] pageZero_reg [tmr_pkg::PAGE_BYTES];
  logic [7:0] pageZero_next [tmr_pkg::PAGE_BYTES];
  logic [7:0] pageOne_reg [tmr_pkg::PAGE_BYTES];
  logic [7:0] pageOne_next [tmr_pkg::PAGE_BYTES];
  logic [7:0] rdData_reg, rdData_next;
  logic irq_reg, irq_next;
  logic [2:0] syncA_reg, syncB_reg, syncC_reg;
  logic gateRiseAny, tick;
  logic wrEn, rdEn, bankOneHit;
  logic [tmr_pkg::TIMER_COUNT-1:0] swTrig, hwTrig, suspend, tOut, zeroP, runClr;
  logic [15:0] countVal [tmr_pkg::TIMER_COUNT];

  // location of byte 'hi' of timer t's data pair
  function automatic logic [4:0] dataAddr(input int t, input logic hi);
    dataAddr = 5'(tmr_pkg::ADDR_T0_LO + 5'(2 * t) + {4'h0, hi});
  endfunction

  // RULE19 two-flop sync, edge on later stages
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      syncA_reg <= 3'h0;
      syncB_reg <= 3'h0;
      syncC_reg <= 3'h0;
    end else begin
      syncA_reg <= {timerClockIn, gateInputOne, gateInputZero};
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
    end
  end

  // RULE4 either gate pin triggers
  assign gateRiseAny = |(syncB_reg[1:0] & ~syncC_reg[1:0]);
  assign tick = syncB_reg[2] & ~syncC_reg[2];
  assign wrEn = busCs & busWr;
  assign rdEn = busCs & busRd;
  // RULE14 bank 1 hides four registers behind 01..04
  assign bankOneHit = !pageSel_reg && bankSel_reg && busAddr != tmr_pkg::ADDR_STATUS
    && busAddr <= tmr_pkg::ADDR_BANK1_LAST;

  always_comb begin
    pageSel_next = pageSel_reg;
    bankSel_next = bankSel_reg;
    ctrl_next = ctrl_reg;
    preset_next = preset_reg;
    hold_next = hold_reg;
    bankOne_next = bankOne_reg;
    pageZero_next = pageZero_reg;
    pageOne_next = pageOne_reg;
    rdData_next = rdData_reg;
    swTrig = '0;
    for (int t = 0; t < tmr_pkg::TIMER_COUNT; t++) begin
      if (runClr[t]) begin
        ctrl_next[t][tmr_pkg::CTRL_RUN_BIT] = 1'b0;
      end
      // RULE10 low byte read clears read bit
      if (rdEn && !pageSel_reg && busAddr == dataAddr(t, 1'b0)) begin
        ctrl_next[t][tmr_pkg::CTRL_READ_BIT] = 1'b0;
      end
    end
    // RULE12 five address bits plus page and bank
    if (wrEn) begin
      if (busAddr == tmr_pkg::ADDR_STATUS) begin
        pageSel_next = busWrData[tmr_pkg::STAT_PAGE_BIT];
        bankSel_next = busWrData[tmr_pkg::STAT_BANK_BIT];
      end else if (pageSel_reg) begin
        pageOne_next[busAddr] = busWrData;
      end else if (bankOneHit) begin
        bankOne_next[2'(busAddr - 5'h01)] = busWrData;
      end else begin
        pageZero_next[busAddr] = busWrData;
        for (int t = 0; t < tmr_pkg::TIMER_COUNT; t++) begin
          if (busAddr == 5'(tmr_pkg::ADDR_CTRL0 + 5'(t))) begin
            // RULE17 writing the read bit low aborts
            ctrl_next[t] = busWrData;
            // RULE9 latch running count
            if (busWrData[tmr_pkg::CTRL_READ_BIT]) begin
              hold_next[t] = countVal[t];
            end
            // RULE16 every one written retriggers
            swTrig[t] = busWrData[tmr_pkg::CTRL_HOLD_BIT];
          end
          if (busAddr == dataAddr(t, 1'b0)) begin
            preset_next[t][7:0] = busWrData;
          end
          if (busAddr == dataAddr(t, 1'b1)) begin
            preset_next[t][15:8] = busWrData;
          end
        end
      end
    end
    if (rdEn) begin
      // RULE13 status visible everywhere
      if (busAddr == tmr_pkg::ADDR_STATUS) begin
        rdData_next = tmr_pkg::BYTE_RESET;
        rdData_next[tmr_pkg::STAT_PAGE_BIT] = pageSel_reg;
        rdData_next[tmr_pkg::STAT_BANK_BIT] = bankSel_reg;
      end else if (pageSel_reg) begin
        rdData_next = pageOne_reg[busAddr];
      end else if (bankOneHit) begin
        rdData_next = bankOne_reg[2'(busAddr - 5'h01)];
      end else begin
        rdData_next = pageZero_reg[busAddr];
        for (int t = 0; t < tmr_pkg::TIMER_COUNT; t++) begin
          if (busAddr == 5'(tmr_pkg::ADDR_CTRL0 + 5'(t))) begin
            rdData_next = ctrl_reg[t];
          end
          // RULE8 preset unless latched
          if (busAddr == dataAddr(t, 1'b0)) begin
            rdData_next = ctrl_reg[t][tmr_pkg::CTRL_READ_BIT] ? hold_reg[t][7:0]
              : preset_reg[t][7:0];
          end
          if (busAddr == dataAddr(t, 1'b1)) begin
            rdData_next = ctrl_reg[t][tmr_pkg::CTRL_READ_BIT] ? hold_reg[t][15:8]
              : preset_reg[t][15:8];
          end
        end
      end
    end
    irq_next = |zeroP;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pageSel_reg <= 1'b0;
      bankSel_reg <= 1'b0;
      ctrl_reg <= '{default: tmr_pkg::CTRL_RESET};
      preset_reg <= '{default: tmr_pkg::COUNT_RESET};
      hold_reg <= '{default: tmr_pkg::COUNT_RESET};
      bankOne_reg <= '{default: tmr_pkg::BYTE_RESET};
      pageZero_reg <= '{default: tmr_pkg::BYTE_RESET};
      pageOne_reg <= '{default: tmr_pkg::BYTE_RESET};
      rdData_reg <= tmr_pkg::BYTE_RESET;
      irq_reg <= 1'b0;
    end else begin
      pageSel_reg <= pageSel_next;
      bankSel_reg <= bankSel_next;
      ctrl_reg <= ctrl_next;
      preset_reg <= preset_next;
      hold_reg <= hold_next;
      bankOne_reg <= bankOne_next;
      pageZero_reg <= pageZero_next;
      pageOne_reg <= pageOne_next;
      rdData_reg <= rdData_next;
      irq_reg <= irq_next;
    end
  end

  assign hwTrig = {2{gateRiseAny}};
  assign suspend = {syncB_reg[1] | ctrl_reg[1][tmr_pkg::CTRL_HOLD_BIT],
    syncB_reg[0] | ctrl_reg[0][tmr_pkg::CTRL_HOLD_BIT]};

  // RULE18 mode bits drive each channel
  for (genvar g = 0; g < tmr_pkg::TIMER_COUNT; g++) begin : gen_timer
    tmr_counter u_counter (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick),
      .runBit(ctrl_reg[g][tmr_pkg::CTRL_RUN_BIT]),
      .modeSel(ctrl_reg[g][tmr_pkg::CTRL_MODE_HI:tmr_pkg::CTRL_MODE_LO]),
      .suspend(suspend[g]),
      .trigger(swTrig[g] | hwTrig[g]),
      .presetValue(preset_reg[g]),
      .countValue(countVal[g]),
      .timerOut(tOut[g]),
      .zeroPulse(zeroP[g]),
      .runClearPulse(runClr[g])
    );
  end

  assign busRdData = rdData_reg;
  assign multiFunctionOutput = tOut[0];
  assign timerOneOutput = tOut[1];
  assign interruptOutput = irq_reg;

  AST_PRESET_READ: assert property (@(posedge sys_clk) disable iff (rst) // RULE8
    (rdEn && !pageSel_reg && busAddr == 5'h0f && !ctrl_reg[0][6])
      |=> busRdData == $past(preset_reg[0][7:0]))
    else $error("timer 0 low byte did not return preset");
  AST_LATCH_READ: assert property (@(posedge sys_clk) disable iff (rst) // RULE9
    (wrEn && !pageSel_reg && !bankSel_reg && busAddr == 5'h02 && busWrData[6])
      ##1 (!wrEn && !rdEn) ##1 (rdEn && busAddr == 5'h12 && !wrEn)
      |=> busRdData == $past(countVal[1][15:8], 3))
    else $error("timer 1 high byte did not return latched count");
  AST_LOW_CLEARS: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
    (rdEn && !wrEn && !pageSel_reg && busAddr == 5'h11) |=> !ctrl_reg[1][6])
    else $error("low byte read left read bit set");
  AST_STATUS_ALL: assert property (@(posedge sys_clk) disable iff (rst) // RULE13
    (rdEn && busAddr == 5'h00) |=> busRdData[7:6] == $past({pageSel_reg, bankSel_reg}))
    else $error("status register missing page or bank bits");
  AST_IRQ_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    interruptOutput |-> $past(zeroP != 2'b00))
    else $error("interrupt without a zero count");
endmodule

// [verilog/tmr_pkg.sv]
// Purpose: shared constants and types for the two-channel countdown timer block
// Assumes: byte-wide register bus with 5 address bits, 25 MHz sys_clk
// Notes: offsets are byte locations as decoded on the address pins
package tmr_pkg;
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_CTRL0 = 5'h01;
  localparam logic [4:0] ADDR_CTRL1 = 5'h02;
  localparam logic [4:0] ADDR_BANK1_LAST = 5'h04;
  localparam logic [4:0] ADDR_T0_LO = 5'h0f;
  localparam logic [4:0] ADDR_T0_HI = 5'h10;
  localparam logic [4:0] ADDR_T1_LO = 5'h11;
  localparam logic [4:0] ADDR_T1_HI = 5'h12;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_MODE_HI = 2;
  localparam int CTRL_READ_BIT = 6;
  localparam int CTRL_HOLD_BIT = 7;
  localparam int STAT_BANK_BIT = 6;
  localparam int STAT_PAGE_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_LAST = 16'h0001;
  localparam int TIMER_COUNT = 2;
  localparam int BANK1_REGS = 4;
  localparam int PAGE_BYTES = 32;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_RATE = 2'b01,
    MODE_SQUARE = 2'b10,
    MODE_ONESHOT = 2'b11
  } tmr_mode_t;

  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } tmr_state_t;
endpackage
